/* rtl/ubl_params.svh */
// ubl_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the serial interface configuration block
`ifndef UBL_PARAMS_SVH
`define UBL_PARAMS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define UBL_OFF_BDH      12'h000
`define UBL_OFF_BDL      12'h004
`define UBL_OFF_C1       12'h008
`define UBL_OFF_C2       12'h00c
`define UBL_OFF_TXDATA   12'h010
`define UBL_OFF_RXDATA   12'h014
`define UBL_OFF_IRQ_STAT 12'h018
`define UBL_OFF_IRQ_EN   12'h01c
`define UBL_OFF_IRQ_CLR  12'h020
`define UBL_OFF_LINE     12'h024

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UBL_BDH_BRK_IE   7
`define UBL_BDH_EDGE_IE  6
`define UBL_C1_LOOP      7
`define UBL_C1_SWAI      5'd6
`define UBL_C1_RECEIVER_SOURCE_SELECT      5
`define UBL_C1_M         4
`define UBL_C1_WAKE      3
`define UBL_C1_ILT       2
`define UBL_C1_PE        1
`define UBL_C1_PT        0
`define UBL_C2_TE        3
`define UBL_C2_RE        2
`define UBL_C2_RWU       1

// status bits: 0 rx full, 1 tx done, 2 parity err, 3 frame err,
// 4 idle, 5 rx edge, 6 break detect
`define UBL_ST_RXF       0
`define UBL_ST_TXC       1
`define UBL_ST_PF        2
`define UBL_ST_FE        3
`define UBL_ST_IDLE      4
`define UBL_ST_EDGE      5
`define UBL_ST_BRK       6
`define UBL_NUM_EV       7

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define UBL_RST_BDH      8'h00
`define UBL_RST_BDL      8'h04
`define UBL_RST_C1       8'h00
`define UBL_OVERSAMPLE   5'd16
`define UBL_IDLE_BITS    4'd10
`define UBL_BRK_BITS     4'd11

`endif

/* rtl/ubl_pkg.sv */
// ubl_pkg.sv: types for the serial interface configuration block
// assumes: nothing beyond the params header
package ubl_pkg;
   typedef enum logic [1:0] {
      UBL_TX_IDLE  = 2'b00,
      UBL_TX_SHIFT = 2'b01
   } ubl_tx_e;

   typedef enum logic [1:0] {
      UBL_RX_IDLE  = 2'b00,
      UBL_RX_START = 2'b01,
      UBL_RX_DATA  = 2'b10,
      UBL_RX_STOP  = 2'b11
   } ubl_rx_e;

   typedef struct packed {
      logic       loop_select;
      logic       stop_in_wait;
      logic       receiver_source_select;
      logic       nine_bit;
      logic       wake_addr;
      logic       idle_type_select;
      logic       parity_enable;
      logic       parity_type;
   } ubl_ctrl_s;
endpackage

/* rtl/ubl_uart.sv */
// ubl_uart.sv: baud generator, line options and a simple serial core
// assumes: apb master on pclk; rx pin async to pclk; cpu_wait from core
`include "ubl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ubl_uart
   import ubl_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cpu_wait,
   input  wire logic        rxd_i,
   input  wire logic        txd_i,
   output logic             txd_o,
   output logic             txd_oe,
   output logic             irq
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]  bdh_buf_r, bdh_r, bdl_r, c2_r;
   ubl_ctrl_s   c1_r;
   logic [6:0]  st_r, ien_r;
   logic        gen_armed_r, txdir_r;
   logic [12:0] div_cnt_r;
   logic [3:0]  os_cnt_r;
   logic        tick_r;
   logic [8:0]  tx_buf_r, rx_data_r;
   logic        tx_pend_r;
   logic        rx_s1_r, rx_s2_r, rxl_r, rwu_clr;
   logic [12:0] divisor;
   logic        wr, sclk_run, txe, rxe, rx_in, par_bit;
   logic        st_set_edge, st_set_brk, st_set_rxf, st_set_txc;
   logic        st_set_pf, st_set_fe, st_set_idle;
   logic [6:0]  st_set;

   assign wr = psel & penable & pwrite;
   assign divisor = {bdh_r[4:0], bdl_r};
   assign txe = c2_r[`UBL_C2_TE];
   assign rxe = c2_r[`UBL_C2_RE];
   // clocks frozen in wait when stop_in_wait set
   assign sclk_run = ~(c1_r.stop_in_wait & cpu_wait);

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `UBL_OFF_BDH:      prdata <= {24'h0, bdh_buf_r[7:6],
                                             1'b0, bdh_buf_r[4:0]};
               `UBL_OFF_BDL:      prdata <= {24'h0, bdl_r};
               `UBL_OFF_C1:       prdata <= {24'h0, c1_r};
               `UBL_OFF_C2:       prdata <= {24'h0, c2_r};
               `UBL_OFF_RXDATA:   prdata <= {23'h0, rx_data_r};
               `UBL_OFF_IRQ_STAT: prdata <= {25'h0, st_r};
               `UBL_OFF_IRQ_EN:   prdata <= {25'h0, ien_r};
               `UBL_OFF_LINE:     prdata <= {29'h0, txdir_r, tx_pend_r,
                                             gen_armed_r};
               default:           prdata <= 32'h0000_0000;
            endcase
         end
         if (psel & ~penable) begin
            case (paddr)
               `UBL_OFF_BDH, `UBL_OFF_BDL, `UBL_OFF_C1, `UBL_OFF_C2,
               `UBL_OFF_TXDATA, `UBL_OFF_RXDATA, `UBL_OFF_IRQ_STAT,
               `UBL_OFF_IRQ_EN, `UBL_OFF_IRQ_CLR, `UBL_OFF_LINE: ;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bdh_buf_r   <= `UBL_RST_BDH;
         bdh_r       <= `UBL_RST_BDH;
         bdl_r       <= `UBL_RST_BDL;
         c1_r        <= `UBL_RST_C1;
         c2_r        <= 8'h00;
         ien_r       <= 7'h00;
         txdir_r     <= 1'b0;
         gen_armed_r <= 1'b0;
      end else if (wr & pready) begin
         case (paddr)
            `UBL_OFF_BDH: bdh_buf_r <= pwdata[7:0];
            `UBL_OFF_BDL: begin
               bdl_r <= pwdata[7:0];
               bdh_r <= bdh_buf_r;
            end
            `UBL_OFF_C1:  c1_r <= pwdata[7:0];
            `UBL_OFF_C2: begin
               c2_r <= pwdata[7:0];
               if (pwdata[`UBL_C2_TE] | pwdata[`UBL_C2_RE])
                  gen_armed_r <= 1'b1;
            end
            `UBL_OFF_IRQ_EN: ien_r <= pwdata[6:0];
            `UBL_OFF_LINE:   txdir_r <= pwdata[2];
            default: ;
         endcase
      end else if (rwu_clr) begin
         c2_r[`UBL_C2_RWU] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // baud generator: tick every divisor clocks, 16 ticks per bit
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= 13'h0001;
         tick_r    <= 1'b0;
      end else if (divisor == 13'h0000 || !gen_armed_r) begin
         div_cnt_r <= 13'h0001;
         tick_r    <= 1'b0;
      end else if (!sclk_run) begin
         tick_r    <= 1'b0;
      end else if (div_cnt_r >= divisor) begin
         div_cnt_r <= 13'h0001;
         tick_r    <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 13'h0001;
         tick_r    <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // transmitter
   // ----------------------------------------------------------------
   ubl_tx_e     tx_st_r;
   logic [10:0] tx_sh_r;
   logic [3:0]  tx_bits_r;
   logic [3:0]  tx_os_r;
   logic [8:0]  tx_word;
   logic        tx_done;

   always_comb begin
      tx_word = tx_buf_r;
      if (c1_r.parity_enable) begin
         if (c1_r.nine_bit)
            tx_word[8] = ^tx_buf_r[7:0] ^ c1_r.parity_type;
         else
            tx_word[7] = ^tx_buf_r[6:0] ^ c1_r.parity_type;
      end
   end

   assign tx_done = tick_r & (tx_os_r == 4'hf) & (tx_bits_r == 4'h1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_r   <= UBL_TX_IDLE;
         tx_sh_r   <= 11'h7ff;
         tx_bits_r <= 4'h0;
         tx_os_r   <= 4'h0;
      end else begin
         unique case (tx_st_r)
            UBL_TX_IDLE: begin
               if (tx_pend_r & txe & tick_r) begin
                  // start, data lsb first, optional ninth, stop
                  tx_sh_r   <= c1_r.nine_bit ?
                               {1'b1, tx_word, 1'b0} :
                               {2'b11, tx_word[7:0], 1'b0};
                  tx_bits_r <= c1_r.nine_bit ? 4'd11 : 4'd10;
                  tx_os_r   <= 4'h0;
                  tx_st_r   <= UBL_TX_SHIFT;
               end
            end
            UBL_TX_SHIFT: begin
               if (tick_r) begin
                  tx_os_r <= tx_os_r + 4'h1;
                  if (tx_os_r == 4'hf) begin
                     tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
                     tx_bits_r <= tx_bits_r - 4'h1;
                     if (tx_bits_r == 4'h1)
                        tx_st_r <= UBL_TX_IDLE;
                  end
               end
            end
            default: tx_st_r <= UBL_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buf_r  <= 9'h000;
         tx_pend_r <= 1'b0;
      end else if (wr & pready & (paddr == `UBL_OFF_TXDATA)) begin
         tx_buf_r  <= pwdata[8:0];
         tx_pend_r <= 1'b1;
      end else if (tx_st_r == UBL_TX_IDLE & tx_pend_r & txe & tick_r) begin
         tx_pend_r <= 1'b0;
      end
   end

   // pin drive; single wire direction follows txdir
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txd_o  <= 1'b1;
         txd_oe <= 1'b0;
      end else begin
         txd_o  <= tx_sh_r[0];
         txd_oe <= txe & ~(c1_r.loop_select &
                   c1_r.receiver_source_select & ~txdir_r);
      end
   end

   // ----------------------------------------------------------------
   // receiver input select and sync
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         // tx pin feeds the receiver only in single wire mode
         rx_s1_r <= (c1_r.loop_select & c1_r.receiver_source_select) ?
                    txd_i : rxd_i;
         rx_s2_r <= rx_s1_r;
      end
   end

   // loop: transmitter output, single wire: tx pin, else rx pin
   assign rx_in = !c1_r.loop_select ? rx_s2_r :
                  (c1_r.receiver_source_select ? rx_s2_r :
                   tx_sh_r[0]);

   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   ubl_rx_e     rx_st_r;
   logic [3:0]  rx_os_r;
   logic [3:0]  rx_bit_r;
   logic [8:0]  rx_sh_r;
   logic [3:0]  idle_cnt_r;
   logic        idle_armed_r, brk_zero_r;
   logic [8:0]  rx_word;

   assign rx_word = c1_r.nine_bit ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
   assign par_bit = c1_r.nine_bit ? ^rx_sh_r : ^rx_sh_r[8:1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_r      <= UBL_RX_IDLE;
         rx_os_r      <= 4'h0;
         rx_bit_r     <= 4'h0;
         rx_sh_r      <= 9'h000;
         rx_data_r    <= 9'h000;
         rxl_r        <= 1'b1;
         idle_cnt_r   <= 4'h0;
         idle_armed_r <= 1'b0;
         brk_zero_r   <= 1'b0;
         st_set_rxf   <= 1'b0;
         st_set_pf    <= 1'b0;
         st_set_fe    <= 1'b0;
         st_set_idle  <= 1'b0;
         st_set_brk   <= 1'b0;
         rwu_clr      <= 1'b0;
      end else begin
         rxl_r       <= rx_in;
         st_set_rxf  <= 1'b0;
         st_set_pf   <= 1'b0;
         st_set_fe   <= 1'b0;
         st_set_idle <= 1'b0;
         st_set_brk  <= 1'b0;
         rwu_clr     <= 1'b0;
         if (tick_r & rxe) begin
            unique case (rx_st_r)
               UBL_RX_IDLE: begin
                  if (!rx_in) begin
                     rx_os_r <= 4'h0;
                     rx_st_r <= UBL_RX_START;
                  end else if (idle_armed_r) begin
                     rx_os_r <= rx_os_r + 4'h1;
                     if (rx_os_r == 4'hf) begin
                        idle_cnt_r <= idle_cnt_r + 4'h1;
                        if (idle_cnt_r == `UBL_IDLE_BITS - 4'h1) begin
                           st_set_idle  <= 1'b1;
                           idle_armed_r <= 1'b0;
                           if (!c1_r.wake_addr)
                              rwu_clr <= 1'b1;
                        end
                     end
                  end
               end
               UBL_RX_START: begin
                  rx_os_r <= rx_os_r + 4'h1;
                  if (rx_os_r == 4'h7) begin
                     rx_os_r  <= 4'h0;
                     rx_bit_r <= 4'h0;
                     rx_st_r  <= rx_in ? UBL_RX_IDLE : UBL_RX_DATA;
                     brk_zero_r <= 1'b1;
                     // idle count from after start bit when idle_type_select is clear
                     idle_cnt_r <= 4'h0;
                     idle_armed_r <= ~c1_r.idle_type_select;
                  end
               end
               UBL_RX_DATA: begin
                  rx_os_r <= rx_os_r + 4'h1;
                  if (rx_os_r == 4'hf) begin
                     rx_sh_r  <= {rx_in, rx_sh_r[8:1]};
                     brk_zero_r <= brk_zero_r & ~rx_in;
                     rx_bit_r <= rx_bit_r + 4'h1;
                     if (rx_bit_r == (c1_r.nine_bit ? 4'd8 : 4'd7))
                        rx_st_r <= UBL_RX_STOP;
                  end
               end
               UBL_RX_STOP: begin
                  rx_os_r <= rx_os_r + 4'h1;
                  if (rx_os_r == 4'hf) begin
                     rx_st_r <= UBL_RX_IDLE;
                     rx_os_r <= 4'h0;
                     if (brk_zero_r & !rx_in)
                        st_set_brk <= 1'b1;
                     else if (!(c2_r[`UBL_C2_RWU] & c1_r.wake_addr &
                                !rx_word[c1_r.nine_bit ? 8 : 7])) begin
                        rx_data_r  <= rx_word;
                        st_set_rxf <= 1'b1;
                        st_set_fe  <= ~rx_in;
                        st_set_pf  <= c1_r.parity_enable &
                                      (par_bit ^ c1_r.parity_type);
                        if (c1_r.wake_addr)
                           rwu_clr <= 1'b1;
                     end
                     if (c1_r.idle_type_select) begin
                        idle_cnt_r   <= 4'h0;
                        idle_armed_r <= 1'b1;
                     end
                  end
               end
               default: rx_st_r <= UBL_RX_IDLE;
            endcase
         end
      end
   end

   assign st_set_edge = rxl_r & ~rx_in & sclk_run;
   assign st_set_txc  = tx_done;
   assign st_set = {st_set_brk, st_set_edge, st_set_idle, st_set_fe,
                    st_set_pf, st_set_txc, st_set_rxf};

   // ----------------------------------------------------------------
   // interrupt status: set wins over clear
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `UBL_NUM_EV; gi = gi + 1) begin : g_st
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               st_r[gi] <= 1'b0;
            else if (st_set[gi])
               st_r[gi] <= 1'b1;
            else if (wr & pready & (paddr == `UBL_OFF_IRQ_CLR) &
                     pwdata[gi])
               st_r[gi] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(st_r & ien_r) |
                (st_r[`UBL_ST_BRK] & bdh_r[`UBL_BDH_BRK_IE]) |
                (st_r[`UBL_ST_EDGE] & bdh_r[`UBL_BDH_EDGE_IE]);
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_bdl_write;
      wr & pready & (paddr == `UBL_OFF_BDL);
   endsequence

   property p_div_load;
      @(posedge pclk) disable iff (!presetn)
      s_bdl_write |=> (bdh_r == $past(bdh_buf_r));
   endproperty
   a_div_load: assert property (p_div_load)
      else $error("divisor high not loaded on low write");

   property p_div_hold;
      @(posedge pclk) disable iff (!presetn)
      !(wr & pready & (paddr == `UBL_OFF_BDL)) |=> $stable(bdh_r);
   endproperty
   a_div_hold: assert property (p_div_hold)
      else $error("divisor high changed without low write");

   property p_zero_off;
      @(posedge pclk) disable iff (!presetn)
      (divisor == 13'h0000) [*2] |-> !tick_r;
   endproperty
   a_zero_off: assert property (p_zero_off)
      else $error("baud tick with zero divisor");

   property p_rate;
      @(posedge pclk) disable iff (!presetn)
      (tick_r & divisor == 13'h0002 & $stable(divisor) & sclk_run)
         |=> !tick_r ##1 (tick_r | !sclk_run | !gen_armed_r);
   endproperty
   a_rate: assert property (p_rate)
      else $error("tick spacing differs from divisor");

   property p_armed;
      @(posedge pclk) disable iff (!presetn)
      !gen_armed_r |-> !tick_r;
   endproperty
   a_armed: assert property (p_armed)
      else $error("tick before first enable");

   property p_wait;
      @(posedge pclk) disable iff (!presetn)
      (c1_r.stop_in_wait & cpu_wait) [*2] |-> !tick_r;
   endproperty
   a_wait: assert property (p_wait)
      else $error("tick while frozen in wait");

   property p_brk_irq;
      @(posedge pclk) disable iff (!presetn)
      (st_r[`UBL_ST_BRK] & bdh_r[`UBL_BDH_BRK_IE]) |=> irq;
   endproperty
   a_brk_irq: assert property (p_brk_irq)
      else $error("break interrupt missing");

   property p_edge_irq;
      @(posedge pclk) disable iff (!presetn)
      (st_r[`UBL_ST_EDGE] & bdh_r[`UBL_BDH_EDGE_IE]) |=> irq;
   endproperty
   a_edge_irq: assert property (p_edge_irq)
      else $error("edge interrupt missing");

   property p_te_drive;
      @(posedge pclk) disable iff (!presetn)
      (!txe) |=> !txd_oe;
   endproperty
   a_te_drive: assert property (p_te_drive)
      else $error("tx pin driven while transmitter off");
endmodule
`default_nettype wire

/* bench/ubl_peer.sv */
// ubl_peer.sv: remote serial device on the far side of the line
// assumes: line idles high, bit time given in pclk cycles by the bench
`timescale 1ns/1ps
`default_nettype none
module ubl_peer (
   input  wire logic       pclk,
   input  wire logic       line_i,
   input  var  int         bit_cyc,
   input  wire logic       nine,
   output logic            rxd_o,
   output logic [8:0]      got,
   output var  int         n_got
);
   // ----------------------------------------------------------------
   // receive and send frames, lsb first
   // ----------------------------------------------------------------
   logic [8:0] sh;
   initial begin
      rxd_o = 1'b1;
      got = '0;
      n_got = 0;
      forever begin
         @(negedge line_i);
         repeat (bit_cyc / 2) @(posedge pclk);
         sh = '0;
         for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_cyc) @(posedge pclk);
            sh[i] = line_i;
         end
         repeat (bit_cyc) @(posedge pclk);
         got = sh;
         n_got++;
      end
   end
   task automatic send(input logic [8:0] v);
      logic [9:0] f;
      f = {1'b1, v[7:0], 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o <= f[i];
         repeat (bit_cyc) @(posedge pclk);
      end
   endtask
endmodule
`default_nettype wire

/* bench/uart_baud_and_line_config_bench.sv */
// uart_baud_and_line_config_bench.sv: self-checking bench of ubl_uart
// assumes: ubl_peer on the serial line, apb master driven from here
`timescale 1ns/1ps
`default_nettype none
module uart_baud_and_line_config_bench;
   // ----------------------------------------------------------------
   // signals, design and far-side model
   // ----------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, cpu_wait, jam;
   logic        pready, pslverr, txd_o, txd_oe, irq, peer_rxd, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [8:0]  got, d;
   logic [7:0]  c1;
   int          n_got, n_mismatch, n_compared, bitc, n0;
   ubl_uart u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_wait(cpu_wait), .rxd_i(peer_rxd & ~jam),
      .txd_i(txd_oe ? txd_o : 1'b1), .txd_o(txd_o), .txd_oe(txd_oe),
      .irq(irq));
   ubl_peer u_peer (.pclk(pclk), .line_i(txd_o), .bit_cyc(bitc),
      .nine(c1[4]), .rxd_o(peer_rxd), .got(got), .n_got(n_got));
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] v);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task automatic poll(input int b);
      int k;
      k = 0;
      do begin
         apb(1'b0, 12'h018, 0);
         k++;
      end while (q[b] !== 1'b1 && k < 400);
   endtask
   task automatic txf(input logic [8:0] v);
      n0 = n_got;
      apb(1'b1, 12'h010, {23'h0, v});
      for (int k = 0; k < 2000 && n_got == n0; k++) @(posedge pclk);
      chk(n_got, n0 + 1);
   endtask
   function automatic logic [8:0] exp_frame(input logic [8:0] v,
                                            input logic [7:0] c);
      logic [8:0] f;
      f = c[4] ? v : {1'b0, v[7:0]};
      if (c[1] && c[4]) f[8] = ^f[7:0] ^ c[0];
      if (c[1] && !c[4]) f[7] = ^f[6:0] ^ c[0];
      return f;
   endfunction
   task automatic complete_run;
      if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, cpu_wait, jam, presetn} = '0;
      paddr = '0;
      pwdata = '0;
      c1 = '0;
      bitc = 32;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      d = 9'($urandom(65));
      rdc(12'h004, 32'hff, 32'h04);
      rdc(12'h024, 32'h1, 32'h0);
      chk(txd_oe, 1'b0);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h02);
      apb(1'b1, 12'h00c, 32'h0c);
      rdc(12'h024, 32'h1, 32'h1);
      chk(txd_oe, 1'b1);
      apb(1'b1, 12'h000, 32'h01);
      rdc(12'h000, 32'hff, 32'h01);
      for (int k = 0; k < 8; k++) begin
         c1 = {3'b000, k[2], 2'($urandom), k[1], k[0]};
         apb(1'b1, 12'h008, {24'h0, c1});
         rdc(12'h008, 32'hff, {24'h0, c1});
         d = 9'($urandom);
         txf(d);
         chk(got, exp_frame(d, c1));
      end
      c1 = 8'h00;
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h020, 32'h7f);
      d = {1'b0, 8'($urandom)};
      u_peer.send(d);
      poll(0);
      chk(q[5], 1'b1);
      rdc(12'h014, 32'h1ff, {23'h0, d});
      apb(1'b1, 12'h020, 32'h7f);
      apb(1'b1, 12'h01c, 32'h0);
      txf(9'h055);
      poll(1);
      chk(irq, 1'b0);
      apb(1'b1, 12'h01c, 32'h02);
      @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, 12'h020, 32'h02);
      @(posedge pclk);
      chk(irq, 1'b0);
      rdc(12'h03c, 32'hffffffff, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, 12'h01c, 32'h0);
      apb(1'b1, 12'h000, 32'h80);
      apb(1'b1, 12'h004, 32'h02);
      apb(1'b1, 12'h020, 32'h7f);
      chk(irq, 1'b0);
      jam <= 1'b1;
      repeat (400) @(posedge pclk);
      jam <= 1'b0;
      poll(6);
      chk(irq, 1'b1);
      apb(1'b1, 12'h008, 32'h40);
      cpu_wait <= 1'b1;
      n0 = n_got;
      apb(1'b1, 12'h010, 32'h0a5);
      repeat (400) @(posedge pclk);
      chk(n_got, n0);
      cpu_wait <= 1'b0;
      for (int k = 0; k < 2000 && n_got == n0; k++) @(posedge pclk);
      chk(got, 9'h0a5);
      apb(1'b1, 12'h008, 32'h80);
      jam <= 1'b1;
      apb(1'b1, 12'h020, 32'h7f);
      d = {1'b0, ~d[7:0]};
      apb(1'b1, 12'h010, {23'h0, d});
      poll(0);
      rdc(12'h014, 32'h1ff, {23'h0, d});
      apb(1'b1, 12'h008, 32'ha0);
      apb(1'b1, 12'h024, 32'h4);
      apb(1'b1, 12'h020, 32'h7f);
      apb(1'b1, 12'h010, {24'h0, ~d[7:0]});
      poll(0);
      rdc(12'h014, 32'h1ff, {24'h0, ~d[7:0]});
      jam <= 1'b0;
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      n0 = n_got;
      apb(1'b1, 12'h010, 32'h0a5);
      repeat (400) @(posedge pclk);
      chk(n_got, n0);
      complete_run();
   end
   initial begin
      #200000;
      n_mismatch++;
      complete_run();
   end
endmodule
`default_nettype wire
